/* File: include/pic_host_map.vh */
// constants for the interrupt controller host-side driver
`ifndef PIC_HOST_MAP_VH
`define PIC_HOST_MAP_VH
`define CLK_PERIOD_NS     8
`define T_STROBE_NS       150
`define T_SETUP_NS        120
`define T_RECOVERY_NS     200
`define STROBE_CYC        ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_CYC      ((`T_RECOVERY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CALL_OPCODE       8'hcd
`define ACK_BYTES         2'h3
`define CNT_W             6
`endif

/* File: hdl/pic_ack_capture.v */
// small memory holding vector bytes captured on acknowledge cycles
`timescale 1ns/1ps
module pic_ack_capture (
    input  wire       clk,      // system clock
    input  wire       rst_n,    // async reset, active low
    input  wire       wr_en,    // write strobe
    input  wire [1:0] wr_addr,  // byte index
    input  wire [7:0] wr_data,  // byte captured
    input  wire [1:0] rd_addr,  // byte to read
    output reg  [7:0] rd_data   // registered read data
);
    reg [7:0] mem [0:3];
    always @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule // pic_ack_capture

/* File: hdl/pic_host.v */
// host-side controller that drives the interrupt controller pins
// How it works
// RL1 - chip select held low around read/write
// RL2 - acknowledge cycles run with select high
// RL3 - write drives select, write strobe, data
// RL4 - read samples bus with select, read low
// RL5 - one shared bus, enable per direction
// RL6 - chain lines belong to devices, untouched
// RL7 - buffer enable pin is device output
// RL8 - master/slave strap driven when unbuffered
// RL9 - attention input synchronised, shown upward
// RL10 - requesters hold lines high until acked
// RL11 - level requests need no host action
// RL12 - host issues three acknowledge pulses
// RL13 - register select set before each strobe
// RL14 - select bit from lowest address line
// RL15 - device arbitrates eight levels alone
// RL16 - device sets in-service on acknowledge
// RL17 - masking handled by device mask
// RL18 - first byte call opcode, then low/high
// RL19 - host never drives bus during read/ack
`timescale 1ns/1ps
`include "pic_host_map.vh"
module pic_host (
    input  wire       CLK_IN,          // 125 MHz clock
    input  wire       RST_N_IN,        // async reset, active low
    input  wire       WR_REQ_IN,       // pulse: write command word
    input  wire       RD_REQ_IN,       // pulse: read status
    input  wire       ACK_REQ_IN,      // pulse: run acknowledge sequence
    input  wire       SEL_IN,          // register select bit for request
    input  wire [7:0] WDATA_IN,        // write data
    input  wire       MASTER_IN,       // strap: 1 master, 0 slave
    input  wire       BUFFERED_IN,     // device is in buffered mode
    output reg        BUSY_OUT,        // transfer in progress
    output reg        DONE_OUT,        // pulse: transfer finished
    output reg  [7:0] RDATA_OUT,       // status byte read
    output reg  [7:0] VEC_OPC_OUT,     // first vector byte
    output reg  [15:0] VEC_ADDR_OUT,   // handler address
    output reg        VEC_ERR_OUT,     // first byte not call opcode
    output reg        ATTN_OUT,        // synchronised attention level
    output reg        CS_N_OUT,        // chip select, low active
    output reg        WR_N_OUT,        // write strobe, low active
    output reg        RD_N_OUT,        // read strobe, low active
    output reg        ACK_N_OUT,       // acknowledge strobe, low active
    output reg        REG_SEL_OUT,     // register select bit
    output reg  [7:0] DATA_OUT,        // data bus drive
    output reg        DATA_OE_N_OUT,   // data bus enable, low drives
    output reg        SPEN_OUT,        // strap drive level
    output reg        SPEN_OE_N_OUT,   // strap enable, low drives
    input  wire [7:0] DATA_IN,         // data bus level
    input  wire       ATTN_IN          // device attention pin
);
    localparam [2:0] S_IDLE = 3'h0, S_SETUP = 3'h1, S_STROBE = 3'h2,
                     S_RECOV = 3'h3, S_CAPT = 3'h4;
    localparam [1:0] K_WR = 2'h0, K_RD = 2'h1, K_ACK = 2'h2;
    localparam integer      STROBE_I = `STROBE_CYC;
    localparam integer      RECOV_I  = `RECOVERY_CYC;
    localparam [`CNT_W-1:0] STROBE_N = STROBE_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] RECOV_N  = RECOV_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] SETUP_N  = 6'h01;

    reg [2:0]        state_q;
    reg [1:0]        kind_q;
    reg [`CNT_W-1:0] cnt_q;
    reg [1:0]        byte_q;
    reg [7:0]        d_s1_q, d_s2_q;
    reg              a_s1_q, a_s2_q;
    reg              cap_we_q;
    reg [1:0]        cap_idx_q;
    reg [1:0]        rd_idx_q;
    reg              unload_q;
    wire [7:0]       cap_rd;

    pic_ack_capture u_cap (
        .clk     (CLK_IN),
        .rst_n   (RST_N_IN),
        .wr_en   (cap_we_q),
        .wr_addr (cap_idx_q),
        .wr_data (d_s2_q),
        .rd_addr (rd_idx_q),
        .rd_data (cap_rd)
    );

    function [`CNT_W-1:0] dec;
        input [`CNT_W-1:0] v;
        dec = (v == 6'h00) ? 6'h00 : v - 6'h01;
    endfunction

    // two-flop synchronisers on device pins
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            d_s1_q <= 8'h00;
            d_s2_q <= 8'h00;
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            ATTN_OUT <= 1'b0;
        end else begin
            d_s1_q <= DATA_IN;
            d_s2_q <= d_s1_q;
            a_s1_q <= ATTN_IN;
            a_s2_q <= a_s1_q;
            ATTN_OUT <= a_s2_q; // [RL9]
        end
    end

    // strap pin driven only outside buffered mode
    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SPEN_OUT <= 1'b1;
            SPEN_OE_N_OUT <= 1'b1;
        end else begin
            SPEN_OUT <= MASTER_IN; // [RL6] [RL8]
            SPEN_OE_N_OUT <= BUFFERED_IN; // [RL7] [RL8]
        end
    end

    always @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q <= S_IDLE;
            kind_q <= K_WR;
            cnt_q <= 6'h00;
            byte_q <= 2'h0;
            cap_we_q <= 1'b0;
            cap_idx_q <= 2'h0;
            rd_idx_q <= 2'h0;
            unload_q <= 1'b0;
            BUSY_OUT <= 1'b0;
            DONE_OUT <= 1'b0;
            RDATA_OUT <= 8'h00;
            VEC_OPC_OUT <= 8'h00;
            VEC_ADDR_OUT <= 16'h0000;
            VEC_ERR_OUT <= 1'b0;
            CS_N_OUT <= 1'b1;
            WR_N_OUT <= 1'b1;
            RD_N_OUT <= 1'b1;
            ACK_N_OUT <= 1'b1;
            REG_SEL_OUT <= 1'b0;
            DATA_OUT <= 8'h00;
            DATA_OE_N_OUT <= 1'b1;
        end else begin
            DONE_OUT <= 1'b0;
            cap_we_q <= 1'b0;
            cnt_q <= dec(cnt_q);
            case (state_q)
                S_IDLE: begin
                    if (unload_q) begin
                        // vector bytes come out of the capture memory in order
                        // read data lag the index by one cycle
                        rd_idx_q <= rd_idx_q + 2'h1;
                        if (rd_idx_q == 2'h1) begin
                            VEC_OPC_OUT <= cap_rd;
                        end
                        if (rd_idx_q == 2'h2) begin
                            VEC_ADDR_OUT[7:0] <= cap_rd; // [RL18]
                        end
                        if (rd_idx_q == 2'h3) begin
                            VEC_ADDR_OUT[15:8] <= cap_rd; // [RL18]
                            VEC_ERR_OUT <= (VEC_OPC_OUT != `CALL_OPCODE); // [RL18]
                            unload_q <= 1'b0;
                            BUSY_OUT <= 1'b0;
                            DONE_OUT <= 1'b1;
                        end
                    end else if (WR_REQ_IN || RD_REQ_IN || ACK_REQ_IN) begin
                        BUSY_OUT <= 1'b1;
                        byte_q <= 2'h0;
                        state_q <= S_SETUP;
                        cnt_q <= SETUP_N;
                        REG_SEL_OUT <= SEL_IN; // [RL13] [RL14]
                        if (WR_REQ_IN) begin
                            kind_q <= K_WR;
                            CS_N_OUT <= 1'b0; // [RL1]
                            DATA_OUT <= WDATA_IN;
                            DATA_OE_N_OUT <= 1'b0; // [RL5]
                        end else if (RD_REQ_IN) begin
                            kind_q <= K_RD;
                            CS_N_OUT <= 1'b0; // [RL1]
                        end else begin
                            kind_q <= K_ACK; // [RL2]
                        end
                    end
                end
                S_SETUP: begin
                    if (cnt_q == 6'h00) begin
                        state_q <= S_STROBE;
                        cnt_q <= STROBE_N;
                        WR_N_OUT <= (kind_q != K_WR); // [RL3]
                        RD_N_OUT <= (kind_q != K_RD); // [RL4]
                        ACK_N_OUT <= (kind_q != K_ACK); // [RL12]
                    end
                end
                S_STROBE: begin
                    if (cnt_q == 6'h00) begin
                        state_q <= (kind_q == K_WR) ? S_RECOV : S_CAPT;
                        cnt_q <= RECOV_N;
                        WR_N_OUT <= 1'b1;
                        RD_N_OUT <= 1'b1;
                        ACK_N_OUT <= 1'b1;
                        if (kind_q == K_RD) begin
                            RDATA_OUT <= d_s2_q; // [RL4]
                        end
                        if (kind_q == K_ACK) begin
                            cap_we_q <= 1'b1; // [RL12] [RL19]
                            cap_idx_q <= byte_q;
                        end
                    end
                end
                S_CAPT: begin
                    state_q <= S_RECOV;
                    CS_N_OUT <= 1'b1;
                end
                S_RECOV: begin
                    CS_N_OUT <= 1'b1;
                    DATA_OE_N_OUT <= 1'b1;
                    if (cnt_q == 6'h00) begin
                        if (kind_q == K_ACK && byte_q != 2'h2) begin
                            byte_q <= byte_q + 2'h1; // [RL12]
                            state_q <= S_SETUP;
                            cnt_q <= SETUP_N;
                        end else begin
                            state_q <= S_IDLE;
                            if (kind_q == K_ACK) begin
                                unload_q <= 1'b1;
                                rd_idx_q <= 2'h0;
                            end else begin
                                BUSY_OUT <= 1'b0;
                                DONE_OUT <= 1'b1;
                            end
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // pic_host

/* File: tb/pic_host_props.sv */
// assertions on the host pin driver
`timescale 1ns/1ps
module pic_host_props (
    input wire       CLK_IN,        // clock
    input wire       RST_N_IN,      // reset
    input wire       BUFFERED_IN,   // buffered
    input wire       ATTN_IN,       // attention
    input wire       ATTN_OUT,      // synced
    input wire       CS_N_OUT,      // select
    input wire       WR_N_OUT,      // write
    input wire       RD_N_OUT,      // read
    input wire       ACK_N_OUT,     // acknowledge
    input wire       REG_SEL_OUT,   // reg select
    input wire [7:0] DATA_OUT,      // bus drive
    input wire       DATA_OE_N_OUT, // bus enable
    input wire       SPEN_OE_N_OUT  // strap enable
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    a_wr_with_cs: assert property (!WR_N_OUT |-> !CS_N_OUT)
        else $error("write unselected");
    a_rd_with_cs: assert property (!RD_N_OUT |-> !CS_N_OUT)
        else $error("read unselected");
    a_ack_no_cs: assert property ($fell(ACK_N_OUT) |-> (CS_N_OUT && !ACK_N_OUT)[*8])
        else $error("bad acknowledge");
    a_bus_released: assert property (!(RD_N_OUT && ACK_N_OUT) |-> DATA_OE_N_OUT)
        else $error("bus driven on read");
    a_wr_data_held: assert property (!WR_N_OUT && $past(!WR_N_OUT) |->
        !DATA_OE_N_OUT && $stable(DATA_OUT))
        else $error("write data moved");
    a_sel_held: assert property (!CS_N_OUT && $past(!CS_N_OUT) |-> $stable(REG_SEL_OUT))
        else $error("select moved");
    a_attn_sync: assert property ($stable(ATTN_IN)[*4] |-> ATTN_OUT == ATTN_IN)
        else $error("attention lost");
    a_strap_en: assert property ($stable(BUFFERED_IN)[*2] |-> SPEN_OE_N_OUT == BUFFERED_IN)
        else $error("strap enable");
endmodule // pic_host_props

/* File: tb/pic_dev_model.sv */
// behavioural interrupt controller seen at its pins
`timescale 1ns/1ps
module pic_dev_model (
    input  wire       rst_n_in,  // reset
    input  wire       cs_n_in,   // select
    input  wire       wr_n_in,   // write
    input  wire       rd_n_in,   // read
    input  wire       ack_n_in,  // acknowledge
    input  wire       sel_in,    // reg select
    input  wire [7:0] hd_in,     // host drive
    input  wire       hoe_n_in,  // host enable
    input  wire [7:0] req_in,    // requests
    input  wire       bad_in,    // corrupt opcode
    output wire [7:0] bus_out,   // bus level
    output wire       attn_out   // attention
);
    reg  [7:0] cmd_q [0:1];
    reg  [7:0] dev_d;
    reg  [7:0] last_q = 8'h00;
    reg  [1:0] cnt_q = 2'h0;
    reg  [2:0] prio_q = 3'h0;
    integer    k;
    wire       rd_act = !cs_n_in && !rd_n_in;
    wire       dev_oe = rd_act || !ack_n_in;
    wire [7:0] live = req_in & ~cmd_q[1];
    assign attn_out = |live;
    // released bus shows inverse of last value
    assign bus_out = dev_oe ? dev_d : (!hoe_n_in ? hd_in : ~last_q);
    always @(bus_out) if (dev_oe || !hoe_n_in) last_q = bus_out;
    always_latch begin
        if (!rst_n_in) begin
            cmd_q[0] = 8'h00;
            cmd_q[1] = 8'h00;
        end else if (!cs_n_in && !wr_n_in) cmd_q[sel_in] = hd_in;
    end
    always_comb begin
        case (cnt_q)
            2'h0: dev_d = bad_in ? 8'hcc : 8'hcd;
            2'h1: dev_d = {cmd_q[0][7:3], prio_q};
            default: dev_d = 8'h12 ^ cmd_q[0];
        endcase
        if (rd_act) dev_d = cmd_q[sel_in];
    end
    always @(posedge ack_n_in or negedge rst_n_in)
        cnt_q <= (!rst_n_in || cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
    always @(negedge ack_n_in)
        if (cnt_q == 2'h0)
            for (k = 7; k >= 0; k = k - 1) if (live[k]) prio_q = k[2:0];
endmodule // pic_dev_model

/* File: tb/tb_top.sv */
// self-checking bench for the host pin driver
`timescale 1ns/1ps
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
    err_count = err_count + 1; $display("unexpected at %0t: %h %h", $time, g, e); end end
module tb_top;
    reg clk = 0, rst_n = 0, wr = 0, rd = 0, ack = 0, sel = 0, mst = 1, buf_m = 0, bad = 0;
    reg [7:0] wd = 8'h00, req = 8'h00;
    reg [7:0] cmd [0:1];
    reg [15:0] ev;
    reg [31:0] rnd;
    integer seed = 8, err_count = 0, compares = 0, cycles = 0, i;
    wire done, busy, verr, attn, cs_n, wr_n, rd_n, ack_n, rsel, doe_n, spen, spen_oe_n, dattn;
    wire [7:0] rdata, vopc, dout, bus;
    wire [15:0] vaddr;
    always #4 clk = ~clk;
    pic_host i_dut (.CLK_IN(clk), .RST_N_IN(rst_n), .WR_REQ_IN(wr), .RD_REQ_IN(rd),
        .ACK_REQ_IN(ack), .SEL_IN(sel), .WDATA_IN(wd), .MASTER_IN(mst), .BUFFERED_IN(buf_m),
        .BUSY_OUT(busy), .DONE_OUT(done), .RDATA_OUT(rdata), .VEC_OPC_OUT(vopc),
        .VEC_ADDR_OUT(vaddr), .VEC_ERR_OUT(verr), .ATTN_OUT(attn), .CS_N_OUT(cs_n),
        .WR_N_OUT(wr_n), .RD_N_OUT(rd_n), .ACK_N_OUT(ack_n), .REG_SEL_OUT(rsel),
        .DATA_OUT(dout), .DATA_OE_N_OUT(doe_n), .SPEN_OUT(spen), .SPEN_OE_N_OUT(spen_oe_n),
        .DATA_IN(bus), .ATTN_IN(dattn));
    pic_dev_model i_dev (.rst_n_in(rst_n), .cs_n_in(cs_n), .wr_n_in(wr_n), .rd_n_in(rd_n),
        .ack_n_in(ack_n), .sel_in(rsel), .hd_in(dout), .hoe_n_in(doe_n), .req_in(req),
        .bad_in(bad), .bus_out(bus), .attn_out(dattn));
    function [2:0] low_bit(input [7:0] v);
        integer k;
        begin
            low_bit = 3'h0;
            for (k = 7; k >= 0; k = k - 1) if (v[k]) low_bit = k[2:0];
        end
    endfunction
    task end_of_test;
        begin
            $display("errors %0d compares %0d", err_count, compares);
            if (err_count == 0 && compares > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task op(input [1:0] kind, input s, input [7:0] d);
        integer n;
        begin
            @(negedge clk);
            {wr, rd, ack} = {kind == 2'h0, kind == 2'h1, kind == 2'h2};
            sel = s;
            wd = d;
            @(negedge clk);
            {wr, rd, ack} = 3'h0;
            `CHK(busy, 1'b1)
            for (n = 0; n < 400 && done !== 1'b1; n = n + 1) @(negedge clk);
            if (n == 400) err_count = err_count + 1;
            `CHK(busy, 1'b0)
            if (kind == 2'h0) cmd[s] = d;
        end
    endtask
    task do_ack(input b);
        begin
            bad = b;
            op(2'h2, 1'b0, 8'h00);
            ev = {8'h12 ^ cmd[0], cmd[0][7:3], low_bit(req & ~cmd[1])};
            `CHK(vopc, b ? 8'hcc : 8'hcd)
            `CHK(verr, b)
            `CHK(vaddr, ev)
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            end_of_test;
        end
    end
    initial begin
        cmd[0] = 8'h00;
        cmd[1] = 8'h00;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            @(negedge clk);
            {mst, buf_m} = i[1:0];
            repeat (3) @(negedge clk);
            `CHK(({spen, spen_oe_n}), i[1:0])
        end
        `CHK(({cs_n, wr_n, rd_n, ack_n, doe_n}), 5'h1f)
        for (i = 0; i < 12; i = i + 1) begin
            rnd = $random(seed);
            req = rnd[15:8]; // held for this iteration, through its acknowledge if one is run
            op(2'h0, rnd[16], rnd[7:0]);
            repeat (6) @(negedge clk);
            `CHK(attn, |(req & ~cmd[1]))
            op(2'h1, 1'b0, rnd[31:24]);
            `CHK(rdata, cmd[0])
            op(2'h1, 1'b1, rnd[31:24]);
            `CHK(rdata, cmd[1])
            if (|(req & ~cmd[1])) do_ack(1'b0);
        end
        req = 8'h81;
        op(2'h0, 1'b1, 8'h01);
        op(2'h0, 1'b0, 8'hf8);
        do_ack(1'b1);
        do_ack(1'b0);
        end_of_test;
    end
endmodule // tb_top
bind pic_host pic_host_props i_props (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
    .BUFFERED_IN(BUFFERED_IN), .ATTN_IN(ATTN_IN), .ATTN_OUT(ATTN_OUT), .CS_N_OUT(CS_N_OUT),
    .WR_N_OUT(WR_N_OUT), .RD_N_OUT(RD_N_OUT), .ACK_N_OUT(ACK_N_OUT), .REG_SEL_OUT(REG_SEL_OUT),
    .DATA_OUT(DATA_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT), .SPEN_OE_N_OUT(SPEN_OE_N_OUT));
